// *** rtl/ckb_key_builder.sv ***
// Classifier key builder: one registered key word per lookup request taken while CE_I is high
// Assumes parser fields, action state and frame bytes are valid with the request
`timescale 1ns/1ns
module ckb_key_builder
   import ckb_pkg::*;
#(
   parameter int FRAME_BYTES = 64,
   parameter int NUM_RNG = 8
)
(
   // Clock, reset, enable
   input wire logic SYS_CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   // Register port
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // Lookup request
   input wire logic LOOKUP_REQ_I,
   input wire ckb_req_t REQ_I,
   input wire ckb_parse_t PARSE_I,
   input wire ckb_action_t ACTION_I,
   input wire logic [FRAME_BYTES*8-1:0] FRAME_I,
   input wire logic [5:0] MASQ_PORT_I,
   // Key to match memory
   output logic KEY_VALID_O,
   output ckb_key_t KEY_O
);

   localparam logic [7:0] RNG_END = 8'(int'(CKB_RNG_OFS) + 8 * NUM_RNG);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic dscp_sel_reg;
   logic [1:0] def_sel_reg;
   logic [5:0] lport_reg;
   logic [15:0] rng_lo_reg [NUM_RNG];
   logic [15:0] rng_hi_reg [NUM_RNG];
   logic [2:0] rng_type_reg [NUM_RNG];
   logic [15:0] count_reg;
   ckb_key_type_t last_type_reg;
   logic [31:0] rdata_reg;
   logic valid_reg;
   ckb_key_t key_reg;
   ckb_key_t key_next;
   logic [31:0] rdata_next;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic aligned = ADDR_I[1:0] == 2'h0;
   wire logic cfg_hit = ADDR_I == CKB_CFG_OFS;
   wire logic stat_hit = ADDR_I == CKB_STAT_OFS;
   wire logic rng_hit = aligned && ADDR_I >= CKB_RNG_OFS && ADDR_I < RNG_END;
   wire logic [7:0] rng_rel = ADDR_I - CKB_RNG_OFS;
   wire logic [2:0] rng_idx = rng_rel[5:3];
   wire logic rng_type_word = rng_rel[2];
   wire logic [31:0] cfg_word = {16'h0000, 2'h0, lport_reg, 5'h00, def_sel_reg, dscp_sel_reg};
   wire logic [31:0] stat_word = {14'h0000, last_type_reg, count_reg};
   wire logic [31:0] rng_word = rng_type_word ? {29'h0, rng_type_reg[rng_idx]}
                                              : {rng_hi_reg[rng_idx], rng_lo_reg[rng_idx]};

   assign rdata_next = !RD_I ? 32'h0 : cfg_hit ? cfg_word : stat_hit ? stat_word
                       : rng_hit ? rng_word : 32'h0;

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         dscp_sel_reg <= 1'b0;
         def_sel_reg <= CKB_DEF_SEL_RST;
         lport_reg <= CKB_LPORT_RST;
         rdata_reg <= 32'h0;
      end
      else if (CE_I)
      begin
         rdata_reg <= rdata_next;
         if (WR_I && cfg_hit)
         begin
            dscp_sel_reg <= WDATA_I[CKB_CFG_DSCP_POS];
            def_sel_reg <= WDATA_I[CKB_CFG_DEF_POS +: 2];
            lport_reg <= WDATA_I[CKB_CFG_LPORT_POS +: 6];
         end
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         for (int i = 0; i < NUM_RNG; i++)
         begin
            rng_lo_reg[i] <= CKB_RNG_LIM_RST;
            rng_hi_reg[i] <= CKB_RNG_LIM_RST;
            rng_type_reg[i] <= CKB_RNG_OFF;
         end
      end
      else if (CE_I && WR_I && rng_hit)
      begin
         if (rng_type_word)
            rng_type_reg[rng_idx] <= WDATA_I[2:0];
         else
         begin
            rng_lo_reg[rng_idx] <= WDATA_I[15:0];
            rng_hi_reg[rng_idx] <= WDATA_I[CKB_RNG_HI_POS +: 16];
         end
      end
   end

   // ----------------------------------------
   // Layer-3 fields
   // ----------------------------------------
   // DSCP source select
   wire logic [5:0] dscp_field = dscp_sel_reg ? PARSE_I.classified_dscp : PARSE_I.frame_dscp;
   wire logic [31:0] dip_field = PARSE_I.ipv4_frame_flag ? PARSE_I.ipv4_dip : PARSE_I.ipv6_dip_low;
   wire logic [31:0] src_llc = {PARSE_I.llc_ctrl, PARSE_I.payload[31:8]};
   wire logic [31:0] src_snap = {PARSE_I.snap_pid, PARSE_I.payload[31:24]};
   wire logic [31:0] src_typed = !PARSE_I.ip_or_snap_flag ? PARSE_I.payload
                                 : PARSE_I.ipv4_frame_flag ? PARSE_I.ipv4_sip : PARSE_I.ipv6_sip_low;
   wire logic [31:0] src_field = PARSE_I.type_or_length_flag ? src_typed
                                 : PARSE_I.ip_or_snap_flag ? src_snap : src_llc;
   wire logic [7:0] proto_field = PARSE_I.ipv4_frame_flag ? PARSE_I.ip_proto : PARSE_I.next_header;

   // ----------------------------------------
   // Range checkers
   // ----------------------------------------
   logic [7:0] rng_mask;

   function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      in_rng = v >= lo && v <= hi;
   endfunction

   for (genvar g = 0; g < 8; g++)
   begin : g_rng
      if (g < NUM_RNG)
      begin : g_on
         wire logic [2:0] t = rng_type_reg[g];
         wire logic [15:0] val = t == CKB_RNG_DPORT ? PARSE_I.dport
                                 : t == CKB_RNG_VID ? {4'h0, PARSE_I.vid}
                                 : t == CKB_RNG_DSCP ? {10'h000, PARSE_I.remapped_dscp}
                                 : t == CKB_RNG_CUSTOM ? PARSE_I.custom_range_value : PARSE_I.sport;
         wire logic either = in_rng(PARSE_I.sport, rng_lo_reg[g], rng_hi_reg[g])
                             || in_rng(PARSE_I.dport, rng_lo_reg[g], rng_hi_reg[g]);
         assign rng_mask[g] = t == CKB_RNG_EITHER ? either
                              : t <= CKB_RNG_CUSTOM && in_rng(val, rng_lo_reg[g], rng_hi_reg[g]);
      end
      else
      begin : g_off
         assign rng_mask[g] = 1'b0;
      end
   end

   // ----------------------------------------
   // Payload windows
   // ----------------------------------------
   // skip Ethernet layer
   wire logic [9:0] win_start = PARSE_I.eth_frame
      ? 10'(CKB_ETH_HDR_BYTES) + 10'(CKB_TAG_BYTES) * {8'h00, PARSE_I.vlan_count} + {2'h0, PARSE_I.frame_ptr}
      : {2'h0, PARSE_I.frame_ptr};
   wire logic [9:0] pay_start = {2'h0, PARSE_I.ip_hdr_offset} + 10'(CKB_IP_PAY_OFS);
   logic [119:0] win_field;
   logic [31:0] pay_field;

   always_comb
   begin
      win_field = '0;
      for (int k = 0; k < CKB_WIN_BYTES; k++)
      begin
         if (int'(win_start) + k < FRAME_BYTES)
            win_field[8 * (CKB_WIN_BYTES - 1 - k) +: 8] = FRAME_I[8 * (int'(win_start) + k) +: 8];
      end
   end

   always_comb
   begin
      pay_field = '0;
      for (int k = 0; k < CKB_IP_PAY_BYTES; k++)
      begin
         if (int'(pay_start) + k < FRAME_BYTES)
            pay_field[8 * (CKB_IP_PAY_BYTES - 1 - k) +: 8] = FRAME_I[8 * (int'(pay_start) + k) +: 8];
      end
   end

   // ----------------------------------------
   // Binding index
   // ----------------------------------------
   // default index
   wire logic [11:0] gidx_default = def_sel_reg == CKB_DEF_LPORT ? {6'h00, lport_reg}
                                    : def_sel_reg == CKB_DEF_MASQ ? {6'h00, MASQ_PORT_I} : 12'h000;
   wire logic use_value = ACTION_I.valid && ACTION_I.next_index_control == CKB_NXT_VALUE;
   wire logic use_service = ACTION_I.valid && ACTION_I.next_index_control == CKB_NXT_SERVICE;
   wire logic [11:0] gidx_field = use_value ? ACTION_I.next_index_value
                                  : use_service ? ACTION_I.service_index : gidx_default;
   wire logic is_full = REQ_I.key_type == CKB_KEY_FULL;

   // ----------------------------------------
   // Key assembly
   // ----------------------------------------
   always_comb
   begin
      key_next = '0;
      key_next.wide_key_type_selector = REQ_I.key_type;
      key_next.first = REQ_I.first_lookup;
      key_next.logical_ingress_port = is_full ? lport_reg : 6'h00;
      key_next.binding_index_is_service_flag = !is_full && use_service;
      key_next.binding_index = is_full ? 12'h000 : gidx_field;
      key_next.dscp_key_field = dscp_field;
      key_next.dest_address_key_field = dip_field;
      key_next.overloaded_source_field = src_field;
      key_next.protocol_key_field = proto_field;
      key_next.range_match_mask = rng_mask;
      key_next.ip_payload_word = pay_field;
      key_next.custom_payload_window = win_field;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         key_reg <= '0;
         valid_reg <= 1'b0;
         count_reg <= 16'h0000;
         last_type_reg <= CKB_KEY_FULL;
      end
      else if (CE_I)
      begin
         valid_reg <= LOOKUP_REQ_I;
         if (LOOKUP_REQ_I)
         begin
            key_reg <= key_next;
            count_reg <= count_reg + 16'h0001;
            last_type_reg <= REQ_I.key_type;
         end
      end
   end

   assign KEY_O = key_reg;
   assign KEY_VALID_O = valid_reg;
   assign RDATA_O = rdata_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);
   wire logic take = LOOKUP_REQ_I && CE_I;

   property p_dscp;
      take |=> KEY_O.dscp_key_field == ($past(dscp_sel_reg) ? $past(PARSE_I.classified_dscp)
                                                             : $past(PARSE_I.frame_dscp));
   endproperty
   a_dscp: assert property (p_dscp) else $error("DSCP key field wrong");
   property p_dip;
      take && PARSE_I.ipv4_frame_flag |=> KEY_O.dest_address_key_field == $past(PARSE_I.ipv4_dip);
   endproperty
   a_dip: assert property (p_dip) else $error("Destination field wrong");
   property p_llc;
      take && !PARSE_I.type_or_length_flag && !PARSE_I.ip_or_snap_flag
         |=> KEY_O.overloaded_source_field[31:24] == $past(PARSE_I.llc_ctrl);
   endproperty
   a_llc: assert property (p_llc) else $error("LLC source layout wrong");
   property p_snap;
      take && !PARSE_I.type_or_length_flag && PARSE_I.ip_or_snap_flag
         |=> KEY_O.overloaded_source_field[31:8] == $past(PARSE_I.snap_pid);
   endproperty
   a_snap: assert property (p_snap) else $error("SNAP source layout wrong");
   property p_src_ip4;
      take && PARSE_I.type_or_length_flag && PARSE_I.ip_or_snap_flag && PARSE_I.ipv4_frame_flag
         |=> KEY_O.overloaded_source_field == $past(PARSE_I.ipv4_sip);
   endproperty
   a_src_ip4: assert property (p_src_ip4) else $error("IPv4 source wrong");
   property p_proto;
      take && !PARSE_I.ipv4_frame_flag |=> KEY_O.protocol_key_field == $past(PARSE_I.next_header);
   endproperty
   a_proto: assert property (p_proto) else $error("Next header not used");
   property p_type;
      take |=> KEY_VALID_O && KEY_O.wide_key_type_selector == $past(REQ_I.key_type)
               && KEY_O.first == $past(REQ_I.first_lookup);
   endproperty
   a_type: assert property (p_type) else $error("Selector or lookup flag wrong");
   property p_port;
      take && REQ_I.key_type == CKB_KEY_FULL |=> KEY_O.logical_ingress_port == $past(lport_reg);
   endproperty
   a_port: assert property (p_port) else $error("Ingress port wrong");
   property p_svc;
      take && REQ_I.key_type != CKB_KEY_FULL && ACTION_I.valid
         && ACTION_I.next_index_control == CKB_NXT_SERVICE
         |=> KEY_O.binding_index_is_service_flag && KEY_O.binding_index == $past(ACTION_I.service_index);
   endproperty
   a_svc: assert property (p_svc) else $error("Service binding wrong");
   property p_def;
      take && REQ_I.key_type != CKB_KEY_FULL && !ACTION_I.valid && def_sel_reg == CKB_DEF_LPORT
         |=> KEY_O.binding_index == {6'h00, $past(lport_reg)};
   endproperty
   a_def: assert property (p_def) else $error("Default binding wrong");
   property p_hold;
      !take ##1 !SRST_I |-> $stable(KEY_O);
   endproperty
   a_hold: assert property (p_hold) else $error("Key changed without request");
   property p_valid;
      CE_I && !LOOKUP_REQ_I |=> !KEY_VALID_O;
   endproperty
   a_valid: assert property (p_valid) else $error("Spurious key valid");

   c_snap: cover property (take && !PARSE_I.type_or_length_flag && PARSE_I.ip_or_snap_flag);
   c_chain: cover property (take && ACTION_I.valid && ACTION_I.next_index_control == CKB_NXT_VALUE);
   c_rng: cover property (KEY_VALID_O && KEY_O.range_match_mask != 8'h00);
   c_b2b: cover property (take ##1 take);
endmodule

// *** rtl/ckb_pkg.sv ***
// Constants and carrier types of the classifier key builder
// Assumes one core clock and a synchronous parser feeding it
package ckb_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CKB_CFG_OFS = 8'h00;
   localparam logic [7:0] CKB_STAT_OFS = 8'h04;
   localparam logic [7:0] CKB_RNG_OFS = 8'h10;
   localparam int CKB_CFG_DSCP_POS = 0;
   localparam int CKB_CFG_DEF_POS = 1;
   localparam int CKB_CFG_LPORT_POS = 8;
   localparam int CKB_STAT_TYPE_POS = 16;
   localparam int CKB_RNG_HI_POS = 16;
   localparam logic [1:0] CKB_DEF_SEL_RST = 2'h0;
   localparam logic [5:0] CKB_LPORT_RST = 6'h00;
   localparam logic [15:0] CKB_RNG_LIM_RST = 16'h0000;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int CKB_ETH_HDR_BYTES = 14;
   localparam int CKB_TAG_BYTES = 4;
   localparam int CKB_IP_PAY_OFS = 20;
   localparam int CKB_IP_PAY_BYTES = 4;
   localparam int CKB_WIN_BYTES = 15;
   // ----------------------------------------
   // Action and configuration codes
   // ----------------------------------------
   localparam logic [1:0] CKB_NXT_NONE = 2'h0;
   localparam logic [1:0] CKB_NXT_VALUE = 2'h1;
   localparam logic [1:0] CKB_NXT_SERVICE = 2'h2;
   localparam logic [1:0] CKB_DEF_ZERO = 2'h0;
   localparam logic [1:0] CKB_DEF_LPORT = 2'h1;
   localparam logic [1:0] CKB_DEF_MASQ = 2'h2;
   localparam logic [2:0] CKB_RNG_SPORT = 3'h0;
   localparam logic [2:0] CKB_RNG_DPORT = 3'h1;
   localparam logic [2:0] CKB_RNG_EITHER = 3'h2;
   localparam logic [2:0] CKB_RNG_VID = 3'h3;
   localparam logic [2:0] CKB_RNG_DSCP = 3'h4;
   localparam logic [2:0] CKB_RNG_CUSTOM = 3'h5;
   localparam logic [2:0] CKB_RNG_OFF = 3'h7;

   typedef enum logic [1:0] {
      CKB_KEY_FULL = 2'h0,
      CKB_KEY_NORMAL = 2'h1,
      CKB_KEY_FIVE = 2'h2,
      CKB_KEY_CUSTOM2 = 2'h3
   } ckb_key_type_t;

   typedef struct packed {
      ckb_key_type_t key_type;
      logic first_lookup;
   } ckb_req_t;

   typedef struct packed {
      logic type_or_length_flag;
      logic ip_or_snap_flag;
      logic ipv4_frame_flag;
      logic eth_frame;
      logic [1:0] vlan_count;
      logic [5:0] frame_dscp;
      logic [5:0] classified_dscp;
      logic [5:0] remapped_dscp;
      logic [31:0] ipv4_dip;
      logic [31:0] ipv6_dip_low;
      logic [31:0] ipv4_sip;
      logic [31:0] ipv6_sip_low;
      logic [7:0] llc_ctrl;
      logic [23:0] snap_pid;
      logic [31:0] payload;
      logic [7:0] ip_proto;
      logic [7:0] next_header;
      logic [15:0] sport;
      logic [15:0] dport;
      logic [11:0] vid;
      logic [15:0] custom_range_value;
      logic [7:0] ip_hdr_offset;
      logic [7:0] frame_ptr;
   } ckb_parse_t;

   typedef struct packed {
      logic valid;
      logic [1:0] next_index_control;
      logic [11:0] next_index_value;
      logic [11:0] service_index;
   } ckb_action_t;

   typedef struct packed {
      ckb_key_type_t wide_key_type_selector;
      logic first;
      logic [5:0] logical_ingress_port;
      logic binding_index_is_service_flag;
      logic [11:0] binding_index;
      logic [5:0] dscp_key_field;
      logic [31:0] dest_address_key_field;
      logic [31:0] overloaded_source_field;
      logic [7:0] protocol_key_field;
      logic [7:0] range_match_mask;
      logic [31:0] ip_payload_word;
      logic [119:0] custom_payload_window;
   } ckb_key_t;
endpackage

// *** testbench/ckb_match_mem_model.sv ***
// Match memory stand-in for the classifier key builder
// Assumes key word and valid are registered on the core clock
`timescale 1ns/1ns
module ckb_match_mem_model
   import ckb_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Key from builder
   input wire logic key_valid_i,
   input wire ckb_key_t key_i,
   // Captured view
   output ckb_key_t last_key_o,
   output logic [15:0] key_count_o
);
   // ----------------------------------------
   // Capture every presented key word
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         last_key_o <= '0;
         key_count_o <= 16'h0000;
      end
      else if (key_valid_i)
      begin
         last_key_o <= key_i;
         key_count_o <= key_count_o + 16'h0001;
      end
   end
endmodule

// *** testbench/classifier_key_field_builder_test.sv ***
// Self-checking bench for the classifier key builder
// Assumes the match memory model captures each key word one cycle after it
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module classifier_key_field_builder_test
   import ckb_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ce = 1'b1;
   logic [31:0] rdata;
   logic req_v = 1'b0;
   ckb_req_t req = '0;
   ckb_parse_t parse = '0;
   ckb_action_t action = '0;
   logic [511:0] frame;
   logic [5:0] masq = 6'h15;
   logic key_valid;
   ckb_key_t key;
   ckb_key_t seen;
   int mismatches = 0;
   int comparisons = 0;
   logic [15:0] n_lookups = 16'h0000;
   logic [31:0] rv;
   ckb_parse_t p;
   logic [2:0] fl [5] = '{3'b000, 3'b010, 3'b111, 3'b110, 3'b100};
   logic [31:0] sx [5] = '{32'h03112233, 32'haabbcc11, 32'hc0a80001, 32'h2001beef, 32'h11223344};

   // ----------------------------------------
   // Design, model and clock
   // ----------------------------------------
   ckb_key_builder u_dut (
      .SYS_CLK_I(clk), .SRST_I(srst), .CE_I(ce),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .LOOKUP_REQ_I(req_v), .REQ_I(req), .PARSE_I(parse), .ACTION_I(action),
      .FRAME_I(frame), .MASQ_PORT_I(masq), .KEY_VALID_O(key_valid), .KEY_O(key)
   );
   ckb_match_mem_model u_mem (
      .clk_i(clk), .srst_i(srst), .key_valid_i(key_valid), .key_i(key),
      .last_key_o(seen), .key_count_o()
   );
   always #50 clk = ~clk;

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic lookup(input ckb_key_type_t t, input logic f, input ckb_parse_t pp, input ckb_action_t a);
      @(posedge clk);
      req <= '{key_type: t, first_lookup: f};
      parse <= pp;
      action <= a;
      req_v <= 1'b1;
      @(posedge clk);
      req_v <= 1'b0;
      n_lookups = n_lookups + 16'h0001;
      #1;
      `CHK(key_valid, 1'b1)
      @(posedge clk);
      #1;
      `CHK(key_valid, 1'b0)
   endtask

   task automatic bind_case(input logic v, input logic [1:0] c, input logic [1:0] d, input logic [11:0] ei,
                            input logic ef);
      reg_write(CKB_CFG_OFS, {18'h0, 6'h2a, 5'h0, d, 1'b0});
      lookup(CKB_KEY_NORMAL, 1'b0, p, '{valid: v, next_index_control: c, next_index_value: 12'h123,
                                        service_index: 12'h456});
      `CHK(seen.binding_index, ei)
      `CHK(seen.binding_index_is_service_flag, ef)
   endtask

   function automatic logic [119:0] window(input int s);
      logic [119:0] w;
      w = '0;
      for (int k = 0; k < 15; k++)
         w[119-8*k -: 8] = (s + k < 64) ? 8'(s + k) : 8'h00;
      return w;
   endfunction

   task automatic end_sim;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      end_sim;
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      for (int n = 0; n < 64; n++)
         frame[8*n +: 8] = 8'(n);
      p = '0;
      p.llc_ctrl = 8'h03;
      p.snap_pid = 24'haabbcc;
      p.payload = 32'h11223344;
      p.ipv4_sip = 32'hc0a80001;
      p.ipv6_sip_low = 32'h2001beef;
      p.ipv4_dip = 32'h0a000001;
      p.ipv6_dip_low = 32'hfe800002;
      p.ip_proto = 8'h06;
      p.next_header = 8'h11;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      reg_read(CKB_CFG_OFS, rv);
      `CHK(rv, 32'h0)
      reg_read(8'h08, rv);
      `CHK(rv, 32'h0)
      reg_read(CKB_RNG_OFS + 8'h04, rv);
      `CHK(rv, 32'h7)
      $display("test registers done");
      for (int i = 0; i < 5; i++)
      begin
         {p.type_or_length_flag, p.ip_or_snap_flag, p.ipv4_frame_flag} = fl[i];
         lookup(CKB_KEY_FIVE, 1'b1, p, '0);
         `CHK(seen.overloaded_source_field, sx[i])
         if (i == 2 || i == 3)
         begin
            `CHK(seen.dest_address_key_field, fl[i][0] ? p.ipv4_dip : p.ipv6_dip_low)
            `CHK(seen.protocol_key_field, fl[i][0] ? 8'h06 : 8'h11)
         end
      end
      $display("test fields done");
      p.frame_dscp = 6'h09;
      p.classified_dscp = 6'h2c;
      lookup(CKB_KEY_FIVE, 1'b1, p, '0);
      `CHK(seen.dscp_key_field, 6'h09)
      reg_write(CKB_CFG_OFS, 32'h1);
      lookup(CKB_KEY_FIVE, 1'b1, p, '0);
      `CHK(seen.dscp_key_field, 6'h2c)
      $display("test dscp done");
      reg_write(CKB_CFG_OFS, 32'h00002a00);
      for (int t = 0; t < 4; t++)
      begin
         lookup(ckb_key_type_t'(t), 1'(t), p, '0);
         `CHK(seen.wide_key_type_selector, 2'(t))
         `CHK(seen.first, 1'(t))
         `CHK(seen.logical_ingress_port, (t == 0) ? 6'h2a : 6'h00)
         reg_read(CKB_STAT_OFS, rv);
         `CHK(rv[17:16], 2'(t))
      end
      $display("test types done");
      bind_case(1'b1, CKB_NXT_VALUE, CKB_DEF_ZERO, 12'h123, 1'b0);
      bind_case(1'b1, CKB_NXT_SERVICE, CKB_DEF_ZERO, 12'h456, 1'b1);
      bind_case(1'b1, CKB_NXT_NONE, CKB_DEF_LPORT, 12'h02a, 1'b0);
      bind_case(1'b1, 2'h3, CKB_DEF_MASQ, 12'h015, 1'b0);
      bind_case(1'b0, CKB_NXT_VALUE, CKB_DEF_ZERO, 12'h000, 1'b0);
      bind_case(1'b0, CKB_NXT_SERVICE, CKB_DEF_LPORT, 12'h02a, 1'b0);
      $display("test binding done");
      p.ip_hdr_offset = 8'd14;
      p.eth_frame = 1'b1;
      p.vlan_count = 2'd2;
      p.frame_ptr = 8'd1;
      lookup(CKB_KEY_FIVE, 1'b1, p, '0);
      `CHK(seen.ip_payload_word, 32'h22232425)
      `CHK(seen.custom_payload_window, window(23))
      p.eth_frame = 1'b0;
      p.frame_ptr = 8'd60;
      lookup(CKB_KEY_FIVE, 1'b1, p, '0);
      `CHK(seen.custom_payload_window, window(60))
      $display("test windows done");
      reg_write(CKB_RNG_OFS, {16'd20, 16'd10});
      reg_write(CKB_RNG_OFS + 8'h04, {29'h0, CKB_RNG_SPORT});
      reg_write(CKB_RNG_OFS + 8'h08, {16'd5, 16'd5});
      reg_write(CKB_RNG_OFS + 8'h0c, {29'h0, CKB_RNG_DSCP});
      reg_write(CKB_RNG_OFS + 8'h10, {16'd200, 16'd100});
      reg_write(CKB_RNG_OFS + 8'h14, {29'h0, CKB_RNG_DPORT});
      reg_write(CKB_RNG_OFS + 8'h18, {16'd201, 16'd200});
      reg_write(CKB_RNG_OFS + 8'h1c, {29'h0, CKB_RNG_EITHER});
      reg_write(CKB_RNG_OFS + 8'h20, {16'd100, 16'd100});
      reg_write(CKB_RNG_OFS + 8'h24, {29'h0, CKB_RNG_VID});
      reg_write(CKB_RNG_OFS + 8'h28, {16'h1234, 16'h1234});
      reg_write(CKB_RNG_OFS + 8'h2c, {29'h0, CKB_RNG_CUSTOM});
      reg_read(CKB_RNG_OFS, rv);
      `CHK(rv, 32'h0014000a)
      p.sport = 16'd20;
      p.dport = 16'd201;
      p.remapped_dscp = 6'd5;
      p.frame_dscp = 6'd9;
      p.vid = 12'd100;
      p.custom_range_value = 16'h1234;
      lookup(CKB_KEY_FIVE, 1'b1, p, '0);
      `CHK(seen.range_match_mask, 8'h3b)
      p.sport = 16'd200;
      p.dport = 16'd150;
      p.remapped_dscp = 6'd9;
      p.frame_dscp = 6'd5;
      p.vid = 12'd101;
      p.custom_range_value = 16'h1235;
      lookup(CKB_KEY_FIVE, 1'b1, p, '0);
      `CHK(seen.range_match_mask, 8'h0c)
      @(posedge clk);
      ce <= 1'b0;
      req_v <= 1'b1;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      req_v <= 1'b0;
      #1;
      `CHK(key_valid, 1'b0)
      reg_read(CKB_STAT_OFS, rv);
      `CHK(rv[15:0], n_lookups)
      $display("test ranges done");
      end_sim;
   end
endmodule
